// ### design/link_sync_pkg.sv
// package of constants and types for the link sync input control block
package link_sync_pkg;
    // ------------------------------------------------------------------
    // configuration encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] SYNC_SEL_SINGLE_ENDED = 2'h0; // single-ended pin
    localparam logic [1:0] SYNC_SEL_DIFFERENTIAL = 2'h1; // differential pin
    localparam logic [1:0] SYNC_SEL_TIMESTAMP    = 2'h2; // timestamp pair
    localparam logic       ENC_8B10B             = 1'h0; // 8b/10b encoding
    localparam logic       ENC_64B66B            = 1'h1; // 64b/66b encoding

    // ------------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 50;  // i_mclk period
    localparam int unsigned ILAS_TIME_NS      = 800; // ilas duration
    localparam int unsigned ILAS_CYCLES       =
        (ILAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  CNT_RESET         = 8'h00; // counter reset

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CGS  = 2'b01,
        ST_ILAS = 2'b10,
        ST_DATA = 2'b11
    } link_state_t;

    typedef struct packed {
        logic [1:0] sync_sel;   // sync source select
        logic       encoding;   // 0: 8b/10b, 1: 64b/66b
        logic       sysref_en;  // sysref receiver power enable
        logic       timestamp_input_pair_en;   // timestamp receiver enable
    } link_cfg_t;

    typedef struct packed {
        logic cgs;   // sending code groups
        logic ilas;  // sending alignment sequence
        logic data;  // sending user data
    } link_phase_t;
endpackage : link_sync_pkg

// ### design/sync_2ff.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
    parameter logic RESET_VAL = 1'b0     // value held during reset
) (
    input  wire logic i_mclk,            // module clock
    input  wire logic i_rst_n,           // async reset, active low
    input  wire logic i_async,           // asynchronous input
    output var  logic o_sync             // synchronised output
);
    logic meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= RESET_VAL;
            o_sync   <= RESET_VAL;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule : sync_2ff
`default_nettype wire

// ### design/jesd_link_sync_input_control.sv
// link start-up control driven by the sync request and sysref pins
`timescale 1ns/1ns
`default_nettype none
module jesd_link_sync_input_control #(
    parameter int unsigned ILAS_LEN = link_sync_pkg::ILAS_CYCLES // ilas len
) (
    input  wire logic                      i_mclk,   // 20 MHz clock
    input  wire logic                      i_rst_n,  // async reset low
    input  wire logic                      i_single_ended_sync_pin_n, // pin
    input  wire logic                      i_differential_sync_pin_n, // pin
    input  wire logic                      i_timestamp_sync_n, // pair level
    input  wire logic                      i_sysref,  // sysref level
    input  wire link_sync_pkg::link_cfg_t  i_cfg,     // configuration
    output var  link_sync_pkg::link_phase_t o_phase,  // link phase
    output var  logic                      o_sysref_rx_pwr_on, // rx power
    output var  logic                      o_timestamp_input_pair_rx_pwr_on,  // rx power
    output var  logic                      o_sysref_aligned,   // lmfc set
    output var  logic                      o_sync_req_active   // req seen
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic se_sync;
    logic diff_sync;
    logic ts_sync;
    logic sysref_sync;

    sync_2ff #(.RESET_VAL(1'b1)) u_se (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async (i_single_ended_sync_pin_n),
        .o_sync  (se_sync)
    );
    sync_2ff #(.RESET_VAL(1'b1)) u_diff (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async (i_differential_sync_pin_n),
        .o_sync  (diff_sync)
    );
    sync_2ff #(.RESET_VAL(1'b1)) u_ts (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async (i_timestamp_sync_n),
        .o_sync  (ts_sync)
    );
    sync_2ff #(.RESET_VAL(1'b0)) u_sysref (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async (i_sysref),
        .o_sync  (sysref_sync)
    );

    // ------------------------------------------------------------------
    // receiver power and gated inputs
    // ------------------------------------------------------------------
    // receivers are powered only while enabled; a dead receiver reads idle
    assign o_sysref_rx_pwr_on = i_cfg.sysref_en;
    assign o_timestamp_input_pair_rx_pwr_on  = i_cfg.timestamp_input_pair_en;

    logic sysref_live;
    logic ts_live_n;
    assign sysref_live = sysref_sync & i_cfg.sysref_en;
    assign ts_live_n   = ts_sync | ~i_cfg.timestamp_input_pair_en;

    // ------------------------------------------------------------------
    // request source selection
    // ------------------------------------------------------------------
    // the active-low request is taken from the selected source only in
    // 8b/10b; in 64b/66b it is forced inactive so the link never waits
    logic req_n;
    always_comb begin
        req_n = 1'b1;
        if (i_cfg.encoding == link_sync_pkg::ENC_8B10B) begin
            case (i_cfg.sync_sel)
                link_sync_pkg::SYNC_SEL_SINGLE_ENDED:
                    req_n = se_sync;
                link_sync_pkg::SYNC_SEL_DIFFERENTIAL:
                    req_n = diff_sync;
                link_sync_pkg::SYNC_SEL_TIMESTAMP:
                    req_n = ts_live_n;
                default:
                    req_n = 1'b1;
            endcase
        end
    end

    logic req;
    assign req = ~req_n;

    // ------------------------------------------------------------------
    // sysref edge detect
    // ------------------------------------------------------------------
    logic sysref_d_reg;
    logic sysref_edge;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sysref_d_reg <= 1'b0;
        end else begin
            sysref_d_reg <= sysref_live;
        end
    end
    assign sysref_edge = sysref_live & ~sysref_d_reg;

    // sticky flag: a sysref edge has aligned the multiframe clock
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sysref_aligned <= 1'b0;
        end else if (!i_cfg.sysref_en) begin
            o_sysref_aligned <= 1'b0;
        end else if (sysref_edge) begin
            o_sysref_aligned <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // link state machine
    // ------------------------------------------------------------------
    link_sync_pkg::link_state_t state_reg;
    link_sync_pkg::link_state_t state_next;
    logic [7:0]                 ilas_cnt_reg;
    logic                       ilas_done;

    assign ilas_done = (ilas_cnt_reg == 8'(ILAS_LEN - 1));

    // ilas waits for a sysref-aligned multiframe before starting when
    // sysref is in use; without sysref it starts on release directly
    logic lmfc_ok;
    assign lmfc_ok = ~i_cfg.sysref_en | o_sysref_aligned;

    // remembers that data was entered straight from idle in 64b/66b, so a
    // later switch to 8b/10b can drop back to waiting for a request
    logic fast_data_reg;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fast_data_reg <= 1'b0;
        end else if (state_reg == link_sync_pkg::ST_IDLE) begin
            fast_data_reg <= (i_cfg.encoding == link_sync_pkg::ENC_64B66B);
        end else if (state_next != link_sync_pkg::ST_DATA) begin
            fast_data_reg <= 1'b0;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            link_sync_pkg::ST_IDLE: begin
                if (i_cfg.encoding == link_sync_pkg::ENC_64B66B) begin
                    state_next = link_sync_pkg::ST_DATA;
                end else if (req) begin
                    state_next = link_sync_pkg::ST_CGS;
                end
            end
            link_sync_pkg::ST_CGS: begin
                if (!req && lmfc_ok) begin
                    state_next = link_sync_pkg::ST_ILAS;
                end
            end
            link_sync_pkg::ST_ILAS: begin
                if (req) begin
                    state_next = link_sync_pkg::ST_CGS;
                end else if (ilas_done) begin
                    state_next = link_sync_pkg::ST_DATA;
                end
            end
            link_sync_pkg::ST_DATA: begin
                if (req) begin
                    state_next = link_sync_pkg::ST_CGS;
                end
            end
            default: state_next = link_sync_pkg::ST_IDLE;
        endcase
        // leaving 64b/66b falls back to waiting for a request
        if (i_cfg.encoding == link_sync_pkg::ENC_8B10B &&
            state_reg == link_sync_pkg::ST_DATA &&
            !req && state_next == link_sync_pkg::ST_DATA &&
            fast_data_reg) begin
            state_next = link_sync_pkg::ST_IDLE;
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= link_sync_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ilas length counter, cleared outside the ilas phase
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ilas_cnt_reg <= link_sync_pkg::CNT_RESET;
        end else if (state_reg == link_sync_pkg::ST_ILAS && !ilas_done) begin
            ilas_cnt_reg <= ilas_cnt_reg + 8'h01;
        end else begin
            ilas_cnt_reg <= link_sync_pkg::CNT_RESET;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_phase           <= '0;
            o_sync_req_active <= 1'b0;
        end else begin
            o_phase.cgs  <= (state_next == link_sync_pkg::ST_CGS);
            o_phase.ilas <= (state_next == link_sync_pkg::ST_ILAS);
            o_phase.data <= (state_next == link_sync_pkg::ST_DATA);
            o_sync_req_active <= req;
        end
    end
endmodule : jesd_link_sync_input_control
`default_nettype wire

// ### sim/link_sync_checker.sv
// port assertions for the link sync input control block
`timescale 1ns/1ns
`default_nettype none
module link_sync_checker #(
    parameter int unsigned ILAS_LEN = 4 // ilas length in cycles
) (
    input wire logic                       i_mclk,  // clock
    input wire logic                       i_rst_n, // reset, active low
    input wire logic                       i_single_ended_sync_pin_n, // pin
    input wire logic                       i_differential_sync_pin_n, // pin
    input wire logic                       i_timestamp_sync_n, // pin
    input wire logic                       i_sysref, // sysref level
    input wire link_sync_pkg::link_cfg_t   i_cfg, // configuration
    input wire link_sync_pkg::link_phase_t o_phase, // link phase
    input wire logic                       o_sysref_rx_pwr_on, // power
    input wire logic                       o_timestamp_input_pair_rx_pwr_on, // power
    input wire logic                       o_sysref_aligned, // aligned
    input wire logic                       o_sync_req_active // request
);
    logic [7:0] ilas_cnt_reg;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // counts the cycles spent in the alignment sequence
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) ilas_cnt_reg <= 8'h00;
        else ilas_cnt_reg <= o_phase.ilas ? ilas_cnt_reg + 8'h01 : 8'h00;
    end
    sysref_pwr_a:
    assert property (o_sysref_rx_pwr_on == i_cfg.sysref_en)
        else $error("sysref power");
    timestamp_input_pair_pwr_a:
    assert property (o_timestamp_input_pair_rx_pwr_on == i_cfg.timestamp_input_pair_en)
        else $error("timestamp_input_pair power");
    phase_onehot_a:
    assert property ($onehot0(o_phase)) else $error("phase not one-hot");
    se_request_a:
    assert property ((i_cfg.sync_sel == 2'h0 && !i_cfg.encoding
        && !i_single_ended_sync_pin_n)[*5]
        |-> o_sync_req_active && o_phase.cgs)
        else $error("low pin did not start cgs");
    enc_ignore_a:
    assert property (i_cfg.encoding[*4] |-> !o_phase.cgs && !o_sync_req_active)
        else $error("request seen in 64b66b");
    source_sel_a:
    assert property ((i_cfg.sync_sel == 2'h1 && i_differential_sync_pin_n)[*5]
        |-> !o_sync_req_active) else $error("unselected pin used");
    ilas_entry_a:
    assert property ($rose(o_phase.ilas) |-> $past(o_phase.cgs)
        && !o_sync_req_active) else $error("ilas out of order");
    ilas_length_a:
    assert property ($fell(o_phase.ilas) && o_phase.data
        |-> ilas_cnt_reg == 8'(ILAS_LEN)) else $error("ilas length");
    align_gate_a:
    assert property ($rose(o_phase.ilas) && i_cfg.sysref_en
        |-> o_sysref_aligned)
        else $error("ilas before sysref");
    align_clear_a:
    assert property (!i_cfg.sysref_en |=> !o_sysref_aligned)
        else $error("aligned kept with sysref off");
    restart_cgs_a:
    assert property (o_phase.data && !i_cfg.encoding ##1 o_sync_req_active
        |-> ##[0:1] o_phase.cgs) else $error("no restart of cgs");
endmodule : link_sync_checker
bind jesd_link_sync_input_control link_sync_checker #(.ILAS_LEN(ILAS_LEN)) chk (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sysref(i_sysref), .i_cfg(i_cfg),
    .i_single_ended_sync_pin_n(i_single_ended_sync_pin_n),
    .i_differential_sync_pin_n(i_differential_sync_pin_n),
    .i_timestamp_sync_n(i_timestamp_sync_n), .o_phase(o_phase),
    .o_sysref_rx_pwr_on(o_sysref_rx_pwr_on),
    .o_sysref_aligned(o_sysref_aligned),
    .o_timestamp_input_pair_rx_pwr_on(o_timestamp_input_pair_rx_pwr_on),
    .o_sync_req_active(o_sync_req_active));
`default_nettype wire

// ### sim/jesd_rx_model.sv
// receiver-side model that drives the single-ended sync request pin
`timescale 1ns/1ns
`default_nettype none
module jesd_rx_model (
    input  wire logic       i_mclk,     // clock
    input  wire logic       i_rst_n,    // reset, active low
    input  wire logic       i_link_req, // ask for a link
    input  wire logic       i_park,     // pin unused, hold at ground
    input  wire logic [3:0] i_hold,     // cgs cycles before release
    input  wire logic       i_cgs,      // device sends code groups
    output var  logic       o_sync_n    // sync request, active low
);
    logic [3:0] seen_reg;
    logic       done_reg;
    // counts code group cycles and releases once enough are seen
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seen_reg <= 4'h0;
            done_reg <= 1'b0;
        end else if (!i_link_req) begin
            seen_reg <= 4'h0;
            done_reg <= 1'b0;
        end else if (i_cgs && !done_reg) begin
            seen_reg <= seen_reg + 4'h1;
            done_reg <= (seen_reg + 4'h1 >= i_hold);
        end
    end
    // grounded when unused, otherwise low while a link is asked for until cgs is done
    assign o_sync_n = !i_park && !(i_link_req && !done_reg);
endmodule : jesd_rx_model
`default_nettype wire

// ### sim/test_jesd_link_sync_input_control.sv
// self-checking bench for the link sync input control block
`timescale 1ns/1ns
`default_nettype none
module test_jesd_link_sync_input_control;
    logic mclk = 0, rst_n = 0, diff_n = 1, ts_n = 1, sysref = 0, se_n;
    logic link_req = 0, park = 0, spwr, tpwr, aligned, req_act;
    logic [3:0] hold = 4'h1;
    link_sync_pkg::link_cfg_t cfg = '0;
    link_sync_pkg::link_phase_t phase;
    int failures = 0, tests_run = 0, cycles = 0, seed = 90, s;
    // clock and cycle ceiling
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end
    jesd_rx_model rx (.i_mclk(mclk), .i_rst_n(rst_n), .i_link_req(link_req),
        .i_park(park), .i_hold(hold), .i_cgs(phase.cgs), .o_sync_n(se_n));
    jesd_link_sync_input_control #(.ILAS_LEN(4)) dut (.i_mclk(mclk),
        .i_rst_n(rst_n), .i_single_ended_sync_pin_n(se_n),
        .i_differential_sync_pin_n(diff_n), .i_timestamp_sync_n(ts_n),
        .i_sysref(sysref), .i_cfg(cfg), .o_phase(phase),
        .o_sysref_rx_pwr_on(spwr), .o_timestamp_input_pair_rx_pwr_on(tpwr),
        .o_sysref_aligned(aligned), .o_sync_req_active(req_act));
    task automatic check(input logic [2:0] seen, input logic [2:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    // expected phase: 0 cgs, 1 ilas, 2 data, 3 idle
    function automatic logic [2:0] ph(input int k);
        return 3'h4 >> k;
    endfunction : ph
    task automatic wait_ph(input int k);
        int n;
        n = 0;
        while (phase !== ph(k) && n < 64) begin
            @(negedge mclk);
            n++;
        end
        check(phase, ph(k));
    endtask : wait_ph
    task automatic restart(input logic [4:0] c);
        @(posedge mclk);
        rst_n <= 0;
        cfg <= link_sync_pkg::link_cfg_t'(c);
        link_req <= 0;
        park <= 0;
        hold <= 4'($random(seed)) | 4'h1;
        repeat (16) @(posedge mclk);
        rst_n <= 1;
        @(negedge mclk);
        check({spwr, tpwr, phase.cgs}, {c[1], c[0], 1'b0});
    endtask : restart
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        // single-ended bring-up, with and without sysref gating
        for (s = 0; s < 4; s++) begin
            restart({3'b000, s[0], 1'($random(seed))});
            @(posedge mclk) link_req <= 1;
            wait_ph(0);
            check({2'b00, req_act}, 3'h1);
            if (s[0]) begin
                repeat (24) @(negedge mclk);
                check(phase, ph(0));
                @(posedge mclk) sysref <= 1;
                repeat (2) @(posedge mclk);
                sysref <= 0;
            end
            wait_ph(1);
            check({2'b00, aligned}, {2'b00, s[0]});
            wait_ph(2);
            @(posedge mclk) link_req <= 0;
            @(posedge mclk) link_req <= 1;
            wait_ph(0);
            @(posedge mclk) cfg.sysref_en <= 0;
            repeat (2) @(negedge mclk);
            check({spwr, aligned, 1'b0}, 3'h0);
            $display("bring-up %0d done", s);
        end
        // 64b/66b with grounded pin goes straight to data
        restart(5'h04);
        @(posedge mclk) park <= 1;
        repeat (10) @(negedge mclk);
        check({phase.data, req_act, 1'b0}, 3'h4);
        $display("64b66b done");
        // other sources: the grounded single-ended pin must not count
        for (s = 1; s < 4; s++) begin
            restart({s[1:0], 3'b001});
            @(posedge mclk) park <= 1;
            repeat (8) @(negedge mclk);
            check({phase.cgs, req_act, 1'b0}, 3'h0);
            @(posedge mclk);
            diff_n <= (s != 1);
            ts_n <= (s != 2);
            repeat (8) @(negedge mclk);
            check({2'b00, req_act}, {2'b00, s != 3});
            @(posedge mclk);
            diff_n <= 1;
            ts_n <= 1;
            if (s != 3) wait_ph(2);
            $display("source %0d done", s);
        end
        // timestamp source with its receiver off must read idle
        restart(5'h10);
        @(posedge mclk) ts_n <= 0;
        repeat (8) @(negedge mclk);
        check({phase.cgs, req_act, 1'b0}, 3'h0);
        @(posedge mclk) ts_n <= 1;
        $display("timestamp off done");
        end_sim();
    end
endmodule : test_jesd_link_sync_input_control
`default_nettype wire
